/* logic/qdw_consts.vh */
`ifndef QDW_CONSTS_VH
`define QDW_CONSTS_VH

// ---------------------------------------------------------------
// register word addresses
// ---------------------------------------------------------------
`define QDW_A_SYM_HI     5'h00
`define QDW_A_SYM_MID    5'h01
`define QDW_A_SYM_LO     5'h02
`define QDW_A_SYM_GAIN   5'h03
`define QDW_A_CAR_HI     5'h04
`define QDW_A_CAR_MID    5'h05
`define QDW_A_CAR_LO     5'h06
`define QDW_A_CGAIN_ACQ  5'h07
`define QDW_A_CGAIN_SS   5'h08
`define QDW_A_STEP_HI    5'h09
`define QDW_A_STEP_LO    5'h0A
`define QDW_A_DWELL_HI   5'h0B
`define QDW_A_DWELL_LO   5'h0C
`define QDW_A_STEP_CNT   5'h0D
`define QDW_A_NB_INIT    5'h0E
`define QDW_A_CONTROL    5'h0F
`define QDW_A_CLEARS     5'h10
`define QDW_A_WB_CTRL    5'h11
`define QDW_A_TONE       5'h12

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define QDW_RST_BYTE     8'h00
`define QDW_RST_CLEARS   8'hFF
`define QDW_RST_WB_CTRL  8'h14
`define QDW_RST_TONE     8'h30

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define QDW_NIB_HI       7:4
`define QDW_SYM_PGAIN    2:0
`define QDW_CAR_PGAIN    3:0
`define QDW_NB_INIT_F    7:2
`define QDW_WB_TC        7:5
`define QDW_B0           0
`define QDW_B1           1
`define QDW_B2           2
`define QDW_B3           3
`define QDW_B4           4
`define QDW_B5           5
`define QDW_B6           6
`define QDW_B7           7

// ---------------------------------------------------------------
// pin synchroniser depth
// ---------------------------------------------------------------
`define QDW_SYNC_LAST    2
`define QDW_SYNC_IDLE    3'h7

`endif

/* logic/qdw_pin_sync.v */
`timescale 1ns/1ns
`include "qdw_consts.vh"

// three-stage synchroniser; output changes once the last two stages agree
module qdw_pin_sync (
	// clock and reset
	input  wire core_clk,
	input  wire reset,
	// pin in, clean level out
	input  wire pinIn,
	output reg  levelOut
);

	// ---------------------------------------------------------------
	// sync chain
	// ---------------------------------------------------------------
	reg [`QDW_SYNC_LAST:0] stage_q;	// stage 0 is read only by stage 1

	// shift the pin through the chain, then accept agreed value
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			// idle high like a released active-low strobe: no false edge after reset
			stage_q  <= `QDW_SYNC_IDLE;
			levelOut <= 1'b1;
		end else begin
			stage_q <= {stage_q[`QDW_SYNC_LAST-1:0], pinIn};
			if (stage_q[`QDW_SYNC_LAST] == stage_q[`QDW_SYNC_LAST-1]) begin
				levelOut <= stage_q[`QDW_SYNC_LAST];
			end
		end
	end

endmodule

/* logic/qdw_write_regs.v */
`timescale 1ns/1ns
`include "qdw_consts.vh"

module qdw_write_regs (
	// clock and reset
	input  wire        core_clk,
	input  wire        reset,
	// parallel host port (pins, active-low strobes)
	input  wire        hostChipEn_n,
	input  wire        hostWriteEn_n,
	input  wire [4:0]  hostAddr,
	input  wire [7:0]  hostData,
	// serial host port, already decoded into bytes by the link slave
	input  wire        serialStart,
	input  wire        serialAddrValid,
	input  wire [7:0]  serialWordAddr,
	input  wire        serialByteValid,
	input  wire [7:0]  serialByte,
	// datapath status
	input  wire        demod_lock_flag,
	// symbol loop
	output reg  [19:0] symbolRateWord,
	output reg  [2:0]  symbolPropGain,
	output reg  [3:0]  symbolIntGain,
	output reg         symbolTrackEn,
	output reg         symbolAccClear,
	// carrier loop
	output reg  [19:0] carrierFreqWord,
	output reg  [3:0]  carrierPropGain,
	output reg  [3:0]  carrierIntGain,
	output reg         carrierTrackEn,
	output reg         carrierAccClear,
	// sweep
	output reg  [15:0] sweepStep,
	output reg  [15:0] dwellSymbols,
	output reg  [7:0]  sweepStepCount,
	output reg         sweepHold,
	output reg         sweepForcePreset,
	// narrowband gain
	output reg  [5:0]  nbGainInitial,
	output reg         nbAdaptEn,
	output reg         nbAccLoad,
	// input conditioning
	output reg         offsetBinary,
	output reg         invertInPhase,
	output reg         autoInvertDetect,
	output reg         biasCancelEn,
	// wide_gain_loop
	output reg         wbExternalInteg,
	output reg         wbDutyInvert,
	output reg         wbIntegFreeze,
	output reg  [2:0]  wbTimeConst,
	output reg         wbAccClear,
	// quality and error counters
	output reg         qualityAccClear,
	output reg         errCountClear,
	// tone and passthrough
	output reg  [7:0]  toneFreqWord,
	output reg         toneHold,
	output reg         passthruEnable
);

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	reg [7:0] symHi_q, symMid_q, symLo_q, symGain_q;	// symbol loop bytes
	reg [7:0] carHi_q, carMid_q, carLo_q;			// carrier word bytes
	reg [7:0] gainAcq_q, gainSs_q;				// carrier gains
	reg [7:0] stepHi_q, stepLo_q, dwellHi_q, dwellLo_q;	// sweep timing
	reg [7:0] stepCnt_q, nbInit_q;				// count, nb gain
	reg [7:0] control_q, clears_q, wbCtrl_q, tone_q;	// control bytes
	reg [4:0] serialPtr_q;					// serial word pointer
	reg       serialArmed_q;				// pointer loaded
	reg       wrPrev_q;					// strobe edge detect

	// ---------------------------------------------------------------
	// synchronised parallel strobes
	// ---------------------------------------------------------------
	wire chipEnSync_n;	// clean chip enable
	wire writeSync_n;	// clean write strobe

	qdw_pin_sync u_sync_ce (
		.core_clk (core_clk),
		.reset    (reset),
		.pinIn    (hostChipEn_n),
		.levelOut (chipEnSync_n)
	);

	qdw_pin_sync u_sync_we (
		.core_clk (core_clk),
		.reset    (reset),
		.pinIn    (hostWriteEn_n),
		.levelOut (writeSync_n)
	);

	// address and data are stable around the strobe; a 2-stage capture suffices
	reg [4:0] addrS1_q, addrS2_q;	// address capture
	reg [7:0] dataS1_q, dataS2_q;	// data capture

	// capture bus ahead of strobe release
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			addrS1_q <= 5'h00;
			addrS2_q <= 5'h00;
			dataS1_q <= 8'h00;
			dataS2_q <= 8'h00;
		end else begin
			addrS1_q <= hostAddr;
			addrS2_q <= addrS1_q;
			dataS1_q <= hostData;
			dataS2_q <= dataS1_q;
		end
	end

	// ---------------------------------------------------------------
	// write arbitration
	// ---------------------------------------------------------------
	wire       parActive = ~writeSync_n & ~chipEnSync_n;	// strobe low
	wire       parWrite  = wrPrev_q & ~parActive;		// end of strobe
	wire       serWrite  = serialByteValid & serialArmed_q;
	reg        wrEn;		// a byte lands this cycle
	reg  [4:0] wrAddr;		// its address
	reg  [7:0] wrData;		// its value

	// parallel write wins if both ports fire together
	always @* begin
		wrEn   = parWrite | serWrite;
		wrAddr = parWrite ? addrS2_q : serialPtr_q;
		wrData = parWrite ? dataS2_q : serialByte;
	end

	// strobe edge history
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wrPrev_q <= 1'b0;
		end else begin
			wrPrev_q <= parActive;
		end
	end

	// serial word pointer, advances after every data byte accepted once an address is loaded
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			serialPtr_q   <= 5'h00;
			serialArmed_q <= 1'b0;
		end else if (serialStart) begin
			serialArmed_q <= 1'b0;
		end else if (serialAddrValid) begin
			serialPtr_q   <= serialWordAddr[4:0];
			serialArmed_q <= 1'b1;
		end else if (serWrite) begin
			serialPtr_q <= serialPtr_q + 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// register bank
	// ---------------------------------------------------------------
	// store each byte at its decoded address
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			symHi_q   <= `QDW_RST_BYTE;
			symMid_q  <= `QDW_RST_BYTE;
			symLo_q   <= `QDW_RST_BYTE;
			symGain_q <= `QDW_RST_BYTE;
			carHi_q   <= `QDW_RST_BYTE;
			carMid_q  <= `QDW_RST_BYTE;
			carLo_q   <= `QDW_RST_BYTE;
			gainAcq_q <= `QDW_RST_BYTE;
			gainSs_q  <= `QDW_RST_BYTE;
			stepHi_q  <= `QDW_RST_BYTE;
			stepLo_q  <= `QDW_RST_BYTE;
			dwellHi_q <= `QDW_RST_BYTE;
			dwellLo_q <= `QDW_RST_BYTE;
			stepCnt_q <= `QDW_RST_BYTE;
			nbInit_q  <= `QDW_RST_BYTE;
			control_q <= `QDW_RST_BYTE;
			clears_q  <= `QDW_RST_CLEARS;
			wbCtrl_q  <= `QDW_RST_WB_CTRL;
			tone_q    <= `QDW_RST_TONE;
		end else if (wrEn) begin
			case (wrAddr)
				`QDW_A_SYM_HI: begin
					symHi_q <= wrData;
				end
				`QDW_A_SYM_MID: begin
					symMid_q <= wrData;
				end
				`QDW_A_SYM_LO: begin
					symLo_q <= wrData;
				end
				`QDW_A_SYM_GAIN: begin
					symGain_q <= wrData;
				end
				`QDW_A_CAR_HI: begin
					carHi_q <= wrData;
				end
				`QDW_A_CAR_MID: begin
					carMid_q <= wrData;
				end
				`QDW_A_CAR_LO: begin
					carLo_q <= wrData;
				end
				`QDW_A_CGAIN_ACQ: begin
					gainAcq_q <= wrData;
				end
				`QDW_A_CGAIN_SS: begin
					gainSs_q <= wrData;
				end
				`QDW_A_STEP_HI: begin
					stepHi_q <= wrData;
				end
				`QDW_A_STEP_LO: begin
					stepLo_q <= wrData;
				end
				`QDW_A_DWELL_HI: begin
					dwellHi_q <= wrData;
				end
				`QDW_A_DWELL_LO: begin
					dwellLo_q <= wrData;
				end
				`QDW_A_STEP_CNT: begin
					stepCnt_q <= wrData;
				end
				`QDW_A_NB_INIT: begin
					nbInit_q <= wrData;
				end
				`QDW_A_CONTROL: begin
					control_q <= wrData;
				end
				`QDW_A_CLEARS: begin
					clears_q <= wrData;
				end
				`QDW_A_WB_CTRL: begin
					wbCtrl_q <= wrData;
				end
				`QDW_A_TONE: begin
					tone_q <= wrData;
				end
				default: begin
					// unmapped or other banks: dropped
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// datapath outputs, registered one cycle after the store
	// ---------------------------------------------------------------
	// decode stored bytes into datapath controls
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			symbolRateWord   <= 20'h00000;
			symbolPropGain   <= 3'h0;
			symbolIntGain    <= 4'h0;
			symbolTrackEn    <= 1'b0;
			symbolAccClear   <= 1'b0;
			carrierFreqWord  <= 20'h00000;
			carrierPropGain  <= 4'h0;
			carrierIntGain   <= 4'h0;
			carrierTrackEn   <= 1'b0;
			carrierAccClear  <= 1'b0;
			sweepStep        <= 16'h0000;
			dwellSymbols     <= 16'h0000;
			sweepStepCount   <= 8'h00;
			sweepHold        <= 1'b0;
			sweepForcePreset <= 1'b0;
			nbGainInitial    <= 6'h00;
			nbAdaptEn        <= 1'b0;
			nbAccLoad        <= 1'b0;
			offsetBinary     <= 1'b0;
			invertInPhase    <= 1'b1;
			autoInvertDetect <= 1'b0;
			biasCancelEn     <= 1'b0;
			wbExternalInteg  <= 1'b0;
			wbDutyInvert     <= 1'b0;
			wbIntegFreeze    <= 1'b0;
			wbTimeConst      <= 3'h0;
			wbAccClear       <= 1'b0;
			qualityAccClear  <= 1'b0;
			errCountClear    <= 1'b0;
			toneFreqWord     <= `QDW_RST_TONE;
			toneHold         <= 1'b0;
			passthruEnable   <= 1'b1;
		end else begin
			symbolRateWord   <= {symHi_q, symMid_q, symLo_q[`QDW_NIB_HI]};
			symbolPropGain   <= symGain_q[`QDW_SYM_PGAIN];
			symbolIntGain    <= symGain_q[`QDW_NIB_HI];
			carrierFreqWord  <= {carHi_q, carMid_q, carLo_q[`QDW_NIB_HI]};
			// acquisition gains until lock, steady state after
			if (demod_lock_flag) begin
				carrierPropGain <= gainSs_q[`QDW_CAR_PGAIN];
				carrierIntGain  <= gainSs_q[`QDW_NIB_HI];
			end else begin
				carrierPropGain <= gainAcq_q[`QDW_CAR_PGAIN];
				carrierIntGain  <= gainAcq_q[`QDW_NIB_HI];
			end
			sweepStep        <= {stepHi_q, stepLo_q};
			sweepStepCount   <= stepCnt_q;
			dwellSymbols     <= {dwellHi_q, dwellLo_q};
			nbGainInitial    <= nbInit_q[`QDW_NB_INIT_F];
			offsetBinary     <= control_q[`QDW_B0];
			invertInPhase    <= ~control_q[`QDW_B1];
			autoInvertDetect <= control_q[`QDW_B7];
			biasCancelEn     <= control_q[`QDW_B2];
			symbolTrackEn    <= control_q[`QDW_B3];
			carrierTrackEn   <= control_q[`QDW_B4];
			sweepHold        <= control_q[`QDW_B5];
			nbAdaptEn        <= control_q[`QDW_B6];
			symbolAccClear   <= ~clears_q[`QDW_B0];
			carrierAccClear  <= ~clears_q[`QDW_B1];
			// clearing the wideband accumulator only matters in digital mode
			wbAccClear       <= ~clears_q[`QDW_B2] & ~wbCtrl_q[`QDW_B0];
			nbAccLoad        <= ~clears_q[`QDW_B3];
			sweepForcePreset <= ~clears_q[`QDW_B5];
			qualityAccClear  <= ~clears_q[`QDW_B6];
			errCountClear    <= ~clears_q[`QDW_B7];
			wbExternalInteg  <= wbCtrl_q[`QDW_B0];
			wbDutyInvert     <= wbCtrl_q[`QDW_B1];
			wbIntegFreeze    <= ~wbCtrl_q[`QDW_B2] & ~wbCtrl_q[`QDW_B0];
			wbTimeConst      <= wbCtrl_q[`QDW_WB_TC];
			toneHold         <= wbCtrl_q[`QDW_B3];
			passthruEnable   <= wbCtrl_q[`QDW_B4];
			toneFreqWord     <= tone_q;
		end
	end

endmodule

/* verification/qdw_write_regs_properties.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// port checker for the write bank
// ------------------------------------------------------------
module qdw_write_regs_properties (
	// clock and reset
	input logic        core_clk,
	input logic        reset,
	// host requests
	input logic        hostChipEn_n,
	input logic        hostWriteEn_n,
	input logic        serialStart,
	input logic        serialAddrValid,
	input logic [7:0]  serialWordAddr,
	input logic        serialByteValid,
	input logic [7:0]  serialByte,
	input logic        demod_lock_flag,
	// watched outputs
	input logic [19:0] symbolRateWord,
	input logic [19:0] carrierFreqWord,
	input logic [3:0]  carrierPropGain,
	input logic [3:0]  carrierIntGain,
	input logic [5:0]  nbGainInitial,
	input logic        offsetBinary,
	input logic        invertInPhase,
	input logic        nbAdaptEn,
	input logic        sweepForcePreset,
	input logic        errCountClear,
	input logic        wbExternalInteg,
	input logic        wbIntegFreeze,
	input logic        wbAccClear,
	input logic [2:0]  wbTimeConst,
	input logic        toneHold,
	input logic        passthruEnable,
	input logic [7:0]  toneFreqWord
);
	logic [4:0] ptr_q;   // serial word pointer
	logic       armed_q; // address byte taken in this transfer
	logic [7:0] byte_q;  // last serial data byte
	logic [3:0] quiet_q; // cycles since any write activity

	// follows the serial pointer and the idle time
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ptr_q   <= 5'h00;
			armed_q <= 1'b0;
			byte_q  <= 8'h00;
			quiet_q <= 4'h0;
		end else begin
			if (serialAddrValid) begin
				ptr_q   <= serialWordAddr[4:0];
				armed_q <= 1'b1;
			end else if (serialStart) begin
				armed_q <= 1'b0;
			end else if (serialByteValid) begin
				ptr_q  <= ptr_q + 5'h01;
				byte_q <= serialByte;
			end
			if ((!hostChipEn_n && !hostWriteEn_n) || serialByteValid) begin
				quiet_q <= 4'h0;
			end else if (quiet_q != 4'hF) begin
				quiet_q <= quiet_q + 4'h1;
			end
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	// an accepted serial data byte aimed at word a, parallel port idle
	sequence s_serByte(logic [4:0] a);
		serialByteValid && armed_q && ptr_q == a && hostChipEn_n && hostWriteEn_n;
	endsequence
	property p_resetVals;
		disable iff (1'b0) reset |-> passthruEnable && invertInPhase && toneFreqWord == 8'h30;
	endproperty
	a_resetVals: assert property (p_resetVals) else $error("reset values wrong");
	property p_serSymHigh;
		s_serByte(5'h00) |-> ##2 symbolRateWord[19:12] == byte_q;
	endproperty
	a_serSymHigh: assert property (p_serSymHigh) else $error("symbol word high");
	property p_serCarLow;
		s_serByte(5'h06) |-> ##2 carrierFreqWord[3:0] == byte_q[7:4];
	endproperty
	a_serCarLow: assert property (p_serCarLow) else $error("carrier word low");
	property p_serNb;
		s_serByte(5'h0E) |-> ##2 nbGainInitial == byte_q[7:2];
	endproperty
	a_serNb: assert property (p_serNb) else $error("narrowband initial");
	property p_serCtrl;
		s_serByte(5'h0F) |-> ##2 offsetBinary == byte_q[0] && invertInPhase == !byte_q[1]
			&& nbAdaptEn == byte_q[6];
	endproperty
	a_serCtrl: assert property (p_serCtrl) else $error("control bits");
	property p_serClears;
		s_serByte(5'h10) |-> ##2 sweepForcePreset == !byte_q[5] && errCountClear == !byte_q[7];
	endproperty
	a_serClears: assert property (p_serClears) else $error("clear bits");
	property p_serWb;
		s_serByte(5'h11) |-> ##2 wbTimeConst == byte_q[7:5] && passthruEnable == byte_q[4]
			&& toneHold == byte_q[3];
	endproperty
	a_serWb: assert property (p_serWb) else $error("wideband control");
	property p_serTone;
		s_serByte(5'h12) |-> ##2 toneFreqWord == byte_q;
	endproperty
	a_serTone: assert property (p_serTone) else $error("tone word");
	property p_wbClearMode;
		wbAccClear |-> !wbExternalInteg;
	endproperty
	a_wbClearMode: assert property (p_wbClearMode) else $error("clear in external mode");
	property p_freezeMode;
		wbIntegFreeze |-> !wbExternalInteg;
	endproperty
	a_freezeMode: assert property (p_freezeMode) else $error("freeze in external mode");
	property p_quietHold;
		quiet_q >= 4'hA && $stable(demod_lock_flag)
			&& $past(demod_lock_flag) == $past(demod_lock_flag, 2)
			|-> $stable({symbolRateWord, carrierFreqWord, carrierPropGain, carrierIntGain});
	endproperty
	a_quietHold: assert property (p_quietHold) else $error("output moved");
endmodule

/* verification/qdw_host_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// host model: parallel pins and serial byte events
// ------------------------------------------------------------
module qdw_host_model (
	// clock
	input  logic       core_clk,
	// parallel pins
	output logic       hostChipEn_n,
	output logic       hostWriteEn_n,
	output logic [4:0] hostAddr,
	output logic [7:0] hostData,
	// serial byte events
	output logic       serialStart,
	output logic       serialAddrValid,
	output logic [7:0] serialWordAddr,
	output logic       serialByteValid,
	output logic [7:0] serialByte
);
	// idle levels from time zero
	initial begin
		hostChipEn_n = 1'b1;
		hostWriteEn_n = 1'b1;
		hostAddr = 5'h1F;
		hostData = 8'hFF;
		{serialStart, serialAddrValid, serialByteValid} = 3'h0;
		serialWordAddr = 8'hFF;
		serialByte = 8'hFF;
	end
	// strobe low four cycles, bus held four more, then released
	task parWrite(input logic [4:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		hostAddr = a;
		hostData = d;
		{hostChipEn_n, hostWriteEn_n} = 2'h0;
		repeat (4) @(posedge core_clk);
		#1;
		{hostChipEn_n, hostWriteEn_n} = 2'h3;
		repeat (4) @(posedge core_clk);
		#1;
		// released bus shows the inverse of the last value
		hostAddr = ~a;
		hostData = ~d;
		repeat (4) @(posedge core_clk);
		// hand back off the edge so callers never drive or sample on it
		#1;
	endtask
	// one-cycle event: 0 start, 1 word address, 2 data byte
	task serPulse(input logic [1:0] kind, input logic [7:0] v);
		@(posedge core_clk);
		#1;
		serialStart = (kind == 2'h0);
		serialAddrValid = (kind == 2'h1);
		serialByteValid = (kind == 2'h2);
		serialWordAddr = v;
		serialByte = v;
		@(posedge core_clk);
		#1;
		{serialStart, serialAddrValid, serialByteValid} = 3'h0;
		serialWordAddr = ~v;
		serialByte = ~v;
	endtask
endmodule

/* verification/test_qpsk_demod_write_regs.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// bench for the write bank
// ------------------------------------------------------------
module test_qpsk_demod_write_regs;
	// clock, reset, lock status, host nets
	logic        core_clk, reset, demod_lock_flag, hostChipEn_n, hostWriteEn_n;
	logic        serialStart, serialAddrValid, serialByteValid;
	logic [4:0]  hostAddr;
	logic [7:0]  hostData, serialWordAddr, serialByte, sweepStepCount, toneFreqWord;
	// design outputs
	logic [19:0] symbolRateWord, carrierFreqWord;
	logic [15:0] sweepStep, dwellSymbols;
	logic [5:0]  nbGainInitial;
	logic [3:0]  symbolIntGain, carrierPropGain, carrierIntGain;
	logic [2:0]  symbolPropGain, wbTimeConst;
	logic        symbolTrackEn, symbolAccClear, carrierTrackEn, carrierAccClear, sweepHold;
	logic        sweepForcePreset, nbAdaptEn, nbAccLoad, offsetBinary, invertInPhase;
	logic        autoInvertDetect, biasCancelEn, wbExternalInteg, wbDutyInvert, wbIntegFreeze;
	logic        wbAccClear, qualityAccClear, errCountClear, toneHold, passthruEnable;
	logic [7:0]  sh [0:18];              // expected register bytes
	logic [7:0]  ctrlSeen, clrSeen;      // outputs regrouped as bytes
	logic [7:0]  wbSeen;
	int          mismatches, check_count, i;
	// rows: address in the upper byte, data in the lower
	localparam logic [15:0] ROWS [0:24] = '{16'h00A5, 16'h013C, 16'h02F0, 16'h03B6, 16'h0481,
		16'h057E, 16'h069F, 16'h0777, 16'h0847, 16'h09C3, 16'h0A5A, 16'h0B12, 16'h0CEF,
		16'h0D80, 16'h0EFF, 16'h0FA5, 16'h0F5A, 16'h11E2, 16'h1000, 16'h10FF, 16'h111D,
		16'h105A, 16'h12C7, 16'h1300, 16'h1F55};
	assign ctrlSeen = {autoInvertDetect, nbAdaptEn, sweepHold, carrierTrackEn, symbolTrackEn,
		biasCancelEn, invertInPhase, offsetBinary};
	assign clrSeen = {errCountClear, qualityAccClear, sweepForcePreset, 1'b0, nbAccLoad,
		wbAccClear, carrierAccClear, symbolAccClear};
	assign wbSeen = {wbTimeConst, passthruEnable, toneHold, wbIntegFreeze, wbDutyInvert,
		wbExternalInteg};
	qdw_write_regs dut_u (.*);
	qdw_host_model host_u (.*);

	// ------------------------------------------------------------
	// checking tasks
	// ------------------------------------------------------------
	task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// expected bytes after reset
	task shReset;
		for (int k = 0; k < 19; k++) sh[k] = 8'h00;
		sh[16] = 8'hFF;
		sh[17] = 8'h14;
		sh[18] = 8'h30;
	endtask
	// compares every output with the expected bytes
	task checkAll;
		logic [7:0] g;
		g = demod_lock_flag ? sh[8] : sh[7];
		check("symWord", symbolRateWord, {sh[0], sh[1], sh[2][7:4]});
		check("symGain", {symbolIntGain, symbolPropGain}, {sh[3][7:4], sh[3][2:0]});
		check("carWord", carrierFreqWord, {sh[4], sh[5], sh[6][7:4]});
		check("carGain", {carrierIntGain, carrierPropGain}, g);
		check("sweep", {sweepStep, sweepStepCount}, {sh[9], sh[10], sh[13]});
		check("dwell", dwellSymbols, {sh[11], sh[12]});
		check("nbInit", nbGainInitial, sh[14][7:2]);
		check("ctrl", ctrlSeen, sh[15] ^ 8'h02);
		check("clears", clrSeen, {~sh[16][7:5], 1'b0, ~sh[16][3], ~sh[16][2] & ~sh[17][0],
			~sh[16][1:0]});
		check("wbCtrl", wbSeen, {sh[17][7:3], ~sh[17][2] & ~sh[17][0], sh[17][1:0]});
		check("tone", toneFreqWord, sh[18]);
	endtask
	// serial transfer: start, word address, n bytes from base upward
	task serBurst(input logic [7:0] a, input int n, input logic [7:0] base);
		logic [4:0] p;
		host_u.serPulse(2'h0, 8'h00);
		host_u.serPulse(2'h1, a);
		p = a[4:0];
		for (int k = 0; k < n; k++) begin
			host_u.serPulse(2'h2, base + 8'(k * 17));
			if (p < 5'h13) sh[p] = base + 8'(k * 17);
			p = p + 5'h01;
		end
		@(posedge core_clk);
		#1;
		checkAll;
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// stimulus
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// cuts a hang short
	initial begin
		repeat (5000) @(posedge core_clk);
		mismatches++;
		summarize;
	end
	initial begin
		reset = 1'b1;
		demod_lock_flag = 1'b0;
		mismatches = 0;
		check_count = 0;
		shReset;
		repeat (16) @(posedge core_clk);
		checkAll;
		#1 reset = 1'b0;
		// every register and two unmapped addresses through the parallel pins
		for (i = 0; i < 25; i++) begin
			host_u.parWrite(ROWS[i][12:8], ROWS[i][7:0]);
			if (ROWS[i][12:8] < 5'h13) sh[ROWS[i][12:8]] = ROWS[i][7:0];
			checkAll;
		end
		// lock moves the carrier loop to the steady gains
		demod_lock_flag = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		checkAll;
		// serial bursts, the last one wrapping past the top address
		serBurst(8'h04, 3, 8'h2D);
		serBurst(8'h0E, 5, 8'h6B);
		serBurst(8'h1F, 2, 8'hC4);
		// data byte after a new start with no address is ignored
		serBurst(8'h00, 0, 8'h00);
		host_u.serPulse(2'h0, 8'h00);
		host_u.serPulse(2'h2, 8'h99);
		repeat (2) @(posedge core_clk);
		#1;
		checkAll;
		// reset in mid-run, then a write at once
		reset = 1'b1;
		repeat (2) @(posedge core_clk);
		shReset;
		checkAll;
		#1 reset = 1'b0;
		host_u.parWrite(5'h12, 8'h81);
		sh[18] = 8'h81;
		checkAll;
		summarize;
	end
endmodule

bind qdw_write_regs qdw_write_regs_properties chk_u (.*);
